// ==== hdl/scan_regs_pkg.sv ====
// Register offsets, reset values and channel-scan constants
package scan_regs_pkg;

  localparam logic [3:0] OFS_CONFIG0   = 4'h0;
  localparam logic [3:0] OFS_DIFF_SEL  = 4'h3;
  localparam logic [3:0] OFS_SE_LOW    = 4'h4;
  localparam logic [3:0] OFS_SE_HIGH   = 4'h5;
  localparam logic [3:0] OFS_MON_SEL   = 4'h6;
  localparam logic [3:0] OFS_PORT_DIR  = 4'h7;
  localparam logic [3:0] OFS_PORT_LVL  = 4'h8;
  localparam logic [3:0] OFS_PART_ID   = 4'h9;

  localparam logic [7:0] RST_DIFF_SEL  = 8'h00;
  localparam logic [7:0] RST_SE_SEL    = 8'hFF;
  localparam logic [7:0] RST_MON_SEL   = 8'h00;
  localparam logic [7:0] RST_PORT_DIR  = 8'hFF;
  localparam logic [7:0] RST_PORT_LVL  = 8'h00;
  localparam logic [7:0] MON_SEL_MASK  = 8'h3D;

  localparam int         ID_VARIANT_BIT = 4;
  localparam int         SCAN_MODE_BIT  = 5;

  // Scan order: 8 pairs, 16 single-ended inputs, then monitor readings
  localparam int         NUM_PAIRS      = 8;
  localparam int         NUM_SINGLE     = 16;
  localparam int         NUM_ENTRIES    = 32;
  localparam logic [4:0] FIRST_SINGLE   = 5'h08;
  localparam logic [4:0] FIRST_MONITOR  = 5'h18;

endpackage

// ==== hdl/scan_select_gpio_id_regs.sv ====
// Scan-selection, port and identification registers with channel pointer
`timescale 1ns/1ns
`default_nettype none

// Function
// R01: Pair bit n measures input 2n against input 2n+1.
// R02: Single-ended channels are measured against the common analog input.
// R03: Scan skips deselected entries and goes straight to the next selected.
// R04: Writing any of the four select registers resets pointer to highest priority.
// R05: Select bit one includes the entry, zero excludes it.
// R06: Host writes zero to fixed-zero select bits.
// R07: Direction bit zero makes pin an output, one an input; resets to all ones.
// R08: Direction and data bit n control port pin n.
// R09: Reading the data register returns sampled pin levels.
// R10: For output pins a data write sets the driven level.
// R11: For input pins a data write has no effect.
// R12: Zero is low, one is high; output latch resets to zero.
// R13: Identification register is read-only; writes ignored.
// R14: Identification bit 4 is one for the 16-bit variant.
// R15: Pair select resets to zero, single-ended selects reset to all ones.
// R16: Host must not leave input pins floating.
// R17: Select registers only steer conversions in automatic scan mode.
// R18: Monitor select has five enable bits, others fixed zero, resets to zero.
// R19: Pointer advances per conversion to next selected entry, wrapping round.
module scan_select_gpio_id_regs
  import scan_regs_pkg::*;
#(
  parameter logic [7:0] PART_ID_VALUE = 8'h15  // Arbitrary value, bit 4 set
) (
  input  wire logic       i_mclk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [3:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  input  wire logic       i_scan_mode_fixed,
  input  wire logic       i_conv_done,
  output logic      [4:0] o_scan_entry,
  output logic            o_scan_valid,
  output logic      [3:0] o_pos_input,
  output logic      [3:0] o_neg_input,
  output logic            o_neg_is_common,
  output logic            o_auto_scan,
  input  wire logic [7:0] i_port_pin,
  output logic      [7:0] o_port_pin,
  output logic      [7:0] o_port_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] diff_pair_select;
  logic [7:0] single_ended_select_low;
  logic [7:0] single_ended_select_high;
  logic [7:0] monitor_reading_select;
  logic [7:0] port_direction;
  logic [7:0] port_level;
  logic [7:0] pin_sync1;
  logic [7:0] pin_sync2;
  logic [7:0] pin_sync3;
  logic [7:0] pin_sampled;
  logic [4:0] scan_ptr;
  logic [7:0] rdata;

  wire        wr_diff = i_reg_wr && (i_reg_addr == OFS_DIFF_SEL);
  wire        wr_sel0 = i_reg_wr && (i_reg_addr == OFS_SE_LOW);
  wire        wr_sel1 = i_reg_wr && (i_reg_addr == OFS_SE_HIGH);
  wire        wr_mon  = i_reg_wr && (i_reg_addr == OFS_MON_SEL);
  wire        wr_dir  = i_reg_wr && (i_reg_addr == OFS_PORT_DIR);
  wire        wr_lvl  = i_reg_wr && (i_reg_addr == OFS_PORT_LVL);
  wire        wr_sel_any = wr_diff | wr_sel0 | wr_sel1 | wr_mon;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      diff_pair_select         <= RST_DIFF_SEL;  // [R15]
      single_ended_select_low  <= RST_SE_SEL;    // [R15]
      single_ended_select_high <= RST_SE_SEL;    // [R15]
      monitor_reading_select   <= RST_MON_SEL;   // [R18]
      port_direction           <= RST_PORT_DIR;  // [R07]
      port_level               <= RST_PORT_LVL;  // [R12]
    end else begin
      if (wr_diff) diff_pair_select <= i_reg_wdata;
      if (wr_sel0) single_ended_select_low <= i_reg_wdata;
      if (wr_sel1) single_ended_select_high <= i_reg_wdata;
      if (wr_mon) monitor_reading_select <= i_reg_wdata & MON_SEL_MASK;  // [R18] [R06]
      if (wr_dir) port_direction <= i_reg_wdata;
      if (wr_lvl) port_level <= i_reg_wdata;  // Latch; only output pins see it [R10]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port pins

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      pin_sync1   <= 8'h00;
      pin_sync2   <= 8'h00;
      pin_sync3   <= 8'h00;
      pin_sampled <= 8'h00;
    end else begin
      pin_sync1 <= i_port_pin;
      pin_sync2 <= pin_sync1;
      pin_sync3 <= pin_sync2;
      for (int b = 0; b < 8; b++) begin
        if (pin_sync2[b] == pin_sync3[b]) pin_sampled[b] <= pin_sync3[b];
      end
    end
  end

  // Bit n of each register drives pin n [R08]
  assign o_port_pin    = port_level;     // [R12]
  assign o_port_pin_oe = ~port_direction; // [R07] [R11]

  ////////////////////////////////////////////////////////////////////////////
  // Scan pointer

  // Entries 24..29: offset, spare, supply, temperature, gain, reference
  wire [31:0] sel_vec = {2'b00, monitor_reading_select[5:2], 1'b0,
                         monitor_reading_select[0],
                         single_ended_select_high, single_ended_select_low,
                         diff_pair_select};  // [R05] [R18]
  wire        any_sel = |sel_vec;

  function automatic logic [4:0] next_sel(input logic [31:0] v, input logic [4:0] from);
    logic [4:0] r;
    logic       hit;
    logic [4:0] idx;
    r   = 5'h00;
    hit = 1'b0;
    for (int k = 1; k <= NUM_ENTRIES; k++) begin
      idx = 5'((int'(from) + k) % NUM_ENTRIES);
      if (!hit && v[idx]) begin
        r   = idx;
        hit = 1'b1;
      end
    end
    return r;
  endfunction

  wire [4:0] first_sel = next_sel(sel_vec, 5'h1F);

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      scan_ptr <= 5'h00;
    end else if (wr_sel_any) begin
      scan_ptr <= 5'h00;  // [R04]
    end else if (!any_sel) begin
      scan_ptr <= 5'h00;
    end else if (!sel_vec[scan_ptr]) begin
      scan_ptr <= first_sel;  // [R03] [R04]
    end else if (i_conv_done && !i_scan_mode_fixed) begin
      scan_ptr <= next_sel(sel_vec, scan_ptr);  // [R19] [R03]
    end
  end

  assign o_auto_scan  = !i_scan_mode_fixed;                         // [R17]
  assign o_scan_entry = scan_ptr;
  assign o_scan_valid = !i_scan_mode_fixed && sel_vec[scan_ptr];    // [R05] [R17]
  wire   is_pair      = scan_ptr < FIRST_SINGLE;
  wire   is_single    = !is_pair && scan_ptr < FIRST_MONITOR;
  wire [4:0] se_idx   = scan_ptr - FIRST_SINGLE;
  assign o_pos_input  = is_pair ? {scan_ptr[2:0], 1'b0} : se_idx[3:0];  // [R01]
  assign o_neg_input  = is_pair ? {scan_ptr[2:0], 1'b1} : 4'h0;         // [R01]
  assign o_neg_is_common = is_single;                                   // [R02]

  ////////////////////////////////////////////////////////////////////////////
  // Read mux

  always_comb begin
    unique case (i_reg_addr)
      OFS_DIFF_SEL: rdata = diff_pair_select;
      OFS_SE_LOW:   rdata = single_ended_select_low;
      OFS_SE_HIGH:  rdata = single_ended_select_high;
      OFS_MON_SEL:  rdata = monitor_reading_select;
      OFS_PORT_DIR: rdata = port_direction;
      OFS_PORT_LVL: rdata = pin_sampled;     // [R09]
      OFS_PART_ID:  rdata = PART_ID_VALUE;   // [R13] [R14]
      default:      rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) o_reg_rdata <= 8'h00;
    else if (i_reg_rd) o_reg_rdata <= rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_sel_write_ptr: assert property (@(posedge i_mclk) disable iff (i_sys_rst)  // [R04]
    wr_sel_any |=> scan_ptr == 5'h00) else $error("pointer not reset by select write");
  a_dir_reset: assert property (@(posedge i_mclk)  // [R07]
    i_sys_rst |=> o_port_pin_oe == 8'h00) else $error("pins not inputs after reset");
  a_lvl_reset: assert property (@(posedge i_mclk)  // [R12]
    i_sys_rst |=> o_port_pin == 8'h00) else $error("output latch not cleared");
  a_sel_reset: assert property (@(posedge i_mclk)  // [R15]
    i_sys_rst |=> diff_pair_select == 8'h00 && single_ended_select_low == 8'hFF)
    else $error("select reset wrong");
  a_mon_mask: assert property (@(posedge i_mclk) disable iff (i_sys_rst)  // [R18]
    (monitor_reading_select & ~MON_SEL_MASK) == 8'h00) else $error("monitor fixed bit set");
  a_id_variant: assert property (@(posedge i_mclk) disable iff (i_sys_rst)  // [R14]
    i_reg_rd && i_reg_addr == OFS_PART_ID |=> o_reg_rdata[ID_VARIANT_BIT])
    else $error("variant bit not one");
  a_lvl_write: assert property (@(posedge i_mclk) disable iff (i_sys_rst)  // [R10]
    wr_lvl |=> o_port_pin == $past(i_reg_wdata)) else $error("level write lost");
  a_ptr_selected: assert property (@(posedge i_mclk) disable iff (i_sys_rst)  // [R19]
    i_conv_done && o_scan_valid && !wr_sel_any |=> sel_vec[scan_ptr] || !any_sel)
    else $error("pointer on deselected entry");
  a_pin_read: assert property (@(posedge i_mclk) disable iff (i_sys_rst)  // [R09]
    i_reg_rd && i_reg_addr == OFS_PORT_LVL |=> o_reg_rdata == $past(pin_sampled))
    else $error("level read wrong");
  a_fixed_hold: assert property (@(posedge i_mclk) disable iff (i_sys_rst)  // [R17]
    i_scan_mode_fixed && !wr_sel_any && sel_vec[scan_ptr] |=> $stable(scan_ptr))
    else $error("pointer moved in fixed mode");
  a_pair_inputs: assert property (@(posedge i_mclk) disable iff (i_sys_rst)  // [R01]
    o_scan_valid && is_pair |-> o_neg_input == o_pos_input + 4'h1 && !o_pos_input[0])
    else $error("pair inputs not neighbours");
  a_single_common: assert property (@(posedge i_mclk) disable iff (i_sys_rst)  // [R02]
    o_scan_valid && is_single |-> o_neg_is_common && o_pos_input == se_idx[3:0])
    else $error("single-ended not against common");
  a_pair_not_common: assert property (@(posedge i_mclk) disable iff (i_sys_rst)  // [R01]
    o_scan_valid && is_pair |-> !o_neg_is_common)
    else $error("pair measured against common");
  a_lvl_keeps_dir: assert property (@(posedge i_mclk) disable iff (i_sys_rst)  // [R11]
    wr_lvl && !wr_dir |=> $stable(o_port_pin_oe))
    else $error("level write changed direction");
  a_id_fixed: assert property (@(posedge i_mclk) disable iff (i_sys_rst)  // [R13]
    i_reg_rd && i_reg_addr == OFS_PART_ID |=> o_reg_rdata == PART_ID_VALUE)
    else $error("identification changed");
  a_high_reset: assert property (@(posedge i_mclk)  // [R15]
    i_sys_rst |=> single_ended_select_high == RST_SE_SEL && monitor_reading_select == RST_MON_SEL)
    else $error("high select or monitor reset wrong");

endmodule

`default_nettype wire

// ==== bench/port_pin_model.sv ====
// External circuit on the general-purpose port pins
`timescale 1ns/1ns
`default_nettype none
module port_pin_model (
  input  wire logic [7:0] i_pin_oe,
  input  wire logic [7:0] i_pin_out,
  input  wire logic [7:0] i_ext_level,
  output logic      [7:0] o_pin_level
);
  // Pins not driven by the device are held by a source, never floating
  assign o_pin_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_level);
endmodule
`default_nettype wire

// ==== bench/scan_select_gpio_id_regs_tb_top.sv ====
// Self-checking bench for the scan-select, port and identification registers
`timescale 1ns/1ns
`default_nettype none
module scan_select_gpio_id_regs_tb_top;
  import scan_regs_pkg::*;
  logic       mclk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic       fixed_mode = 1'b0, conv_done = 1'b0, scan_valid, neg_common, auto_scan;
  logic [3:0] reg_addr = 4'h0, pos_in, neg_in;
  logic [7:0] wdata = 8'h00, ext_level = 8'h00, rdata, pin_out, pin_oe, pin_level, v, d, dir;
  logic [7:0] s [4];
  logic [4:0] scan_entry;
  logic [31:0] sel;
  int         err_total = 0, n_checks = 0, cycles = 0, cur;

  always #4 mclk = ~mclk;

  scan_select_gpio_id_regs i_dut (.i_mclk(mclk), .i_sys_rst(sys_rst), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .i_reg_addr(reg_addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_scan_mode_fixed(fixed_mode), .i_conv_done(conv_done), .o_scan_entry(scan_entry),
    .o_scan_valid(scan_valid), .o_pos_input(pos_in), .o_neg_input(neg_in),
    .o_neg_is_common(neg_common), .o_auto_scan(auto_scan), .i_port_pin(pin_level),
    .o_port_pin(pin_out), .o_port_pin_oe(pin_oe));
  port_pin_model i_pins (.i_pin_oe(pin_oe), .i_pin_out(pin_out), .i_ext_level(ext_level),
    .o_pin_level(pin_level));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("Checks %0d, errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] dat);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    wdata = dat;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 1'b0;
    @(negedge mclk);
    q = rdata;
  endtask

  // Reference scan order: next selected entry after c, wrapping round
  function automatic int nxt(input int c);
    for (int i = 1; i <= 32; i++) if (sel[(c + i) % 32]) return (c + i) % 32;
    return c;
  endfunction

  task automatic chk_entry;
    chk({3'h0, scan_entry}, 8'(cur));
    chk({7'h0, scan_valid}, 8'h01);
    if (cur < 8) begin
      chk({4'h0, pos_in}, 8'(2 * cur));
      chk({4'h0, neg_in}, 8'(2 * cur + 1));
      chk({7'h0, neg_common}, 8'h00);
    end else if (cur < 24) begin
      chk({4'h0, pos_in}, 8'(cur - 8));
      chk({7'h0, neg_common}, 8'h01);
    end
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 6000) begin
      err_total++;
      tally_and_finish;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    v = $urandom(32'h454E07C7);
    repeat (20) @(negedge mclk);
    sys_rst = 1'b0;
    rd(OFS_DIFF_SEL, v);
    chk(v, RST_DIFF_SEL);
    rd(OFS_SE_LOW, v);
    chk(v, RST_SE_SEL);
    rd(OFS_SE_HIGH, v);
    chk(v, RST_SE_SEL);
    rd(OFS_MON_SEL, v);
    chk(v, RST_MON_SEL);
    rd(OFS_PORT_DIR, v);
    chk(v, RST_PORT_DIR);
    chk(pin_oe, 8'h00);
    chk(pin_out, RST_PORT_LVL);
    rd(OFS_PART_ID, v);
    chk({7'h0, v[ID_VARIANT_BIT]}, 8'h01);
    wr(OFS_PART_ID, ~v);
    rd(OFS_PART_ID, d);
    chk(d, v);
    rd(4'hA, v);
    chk(v, 8'h00);
    repeat (4) begin
      dir = 8'($urandom);
      d = 8'($urandom);
      ext_level = 8'($urandom);
      wr(OFS_PORT_DIR, dir);
      wr(OFS_PORT_LVL, d);
      @(negedge mclk);
      chk(pin_oe, ~dir);
      chk(pin_out & ~dir, d & ~dir);
      repeat (6) @(negedge mclk);
      rd(OFS_PORT_LVL, v);
      chk(v, (~dir & d) | (dir & ext_level));
    end
    repeat (3) begin
      for (int k = 0; k < 4; k++) begin
        s[k] = 8'($urandom);
        if (k == 3) s[k] = s[k] & MON_SEL_MASK;
        wr(OFS_DIFF_SEL + 4'(k), s[k]);
      end
      for (int k = 0; k < 4; k++) begin
        rd(OFS_DIFF_SEL + 4'(k), v);
        chk(v, s[k]);
      end
      wr(OFS_SE_HIGH, s[2]);
      sel = {2'b00, s[3][5:0], s[2], s[1], s[0]};
      cur = nxt(31);
      repeat (3) @(negedge mclk);
      chk_entry;
      repeat (8) begin
        conv_done = 1'b1;
        @(negedge mclk);
        conv_done = 1'b0;
        @(negedge mclk);
        cur = nxt(cur);
        chk_entry;
      end
      fixed_mode = 1'b1;
      @(negedge mclk);
      chk({7'h0, scan_valid}, 8'h00);
      chk({7'h0, auto_scan}, 8'h00);
      conv_done = 1'b1;
      @(negedge mclk);
      conv_done = 1'b0;
      @(negedge mclk);
      chk({3'h0, scan_entry}, 8'(cur));
      fixed_mode = 1'b0;
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
